// >>> pbc_pkg.sv
/*
 * Constants for the PLL programming and base clock selector block.
 * Assumes a single 100 MHz reference clock for all synchronous logic.
 */
package pbc_pkg;
	// ********************************************************
	// Field widths and positions of the PLL programming registers
	// ********************************************************
	localparam int PRE_W = 2;
	localparam int VPR_W = 2;
	localparam int CTL_W = 8;
	localparam int CTL_ON_BIT = 5;
	localparam int CTL_BCS_BIT = 4;
	localparam int CTL_PRE_LSB = 2;
	localparam int CTL_VPR_LSB = 0;
	localparam int MUL_W = 12;
	localparam int LIN_W = 8;
	localparam int DIV_W = 4;
	// ********************************************************
	// Reset values
	// ********************************************************
	localparam logic RST_ON = 1'b1;
	localparam logic RST_BCS = 1'b0;
	localparam logic [PRE_W-1:0] RST_PRE = 2'h0;
	localparam logic [VPR_W-1:0] RST_VPR = 2'h0;
	localparam logic [MUL_W-1:0] RST_MUL = 12'h040;
	localparam logic [LIN_W-1:0] RST_LIN = 8'h40;
	localparam logic [DIV_W-1:0] RST_DIV = 4'h1;
	// ********************************************************
	// Frequency and timing constants
	// ********************************************************
	localparam int F_NOM_HZ = 38400;
	localparam int SETTLE_CYC = 3;
	localparam int SYNC_STAGES = 3;
	// Selector states
	typedef enum logic [1:0] {
		PBC_RUN = 2'b00,
		PBC_STOP_OLD = 2'b01,
		PBC_START_NEW = 2'b10
	} pbc_sel_t;
endpackage : pbc_pkg

// >>> pbc_clk_sync.sv
/*
 * Three-stage synchroniser with agreement filter for a clock arriving
 * from outside the ref_clk_i domain. Reports rising edges as pulses.
 */
`timescale 1ns/100ps
module pbc_clk_sync
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic async_i,
	output logic level_o,
	output logic rise_o
);
	import pbc_pkg::*;
	logic [SYNC_STAGES-1:0] sync_ff;
	logic level_ff;
	// Stage 0 is read only by stage 1
	wire agree = sync_ff[1] == sync_ff[2];
	wire nxt_level = agree ? sync_ff[2] : level_ff;
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sync_ff <= '0;
			level_ff <= 1'b0;
		end
		else
		begin
			sync_ff <= {sync_ff[SYNC_STAGES-2:0], async_i};
			level_ff <= nxt_level;
		end
	end
	assign level_o = level_ff;
	assign rise_o = nxt_level & ~level_ff;
endmodule : pbc_clk_sync

// >>> pbc_top.sv
/*
 * PLL programming registers and glitch-free base clock selector.
 * Assumes oscillator and divided VCO clocks are slow relative to
 * ref_clk_i (below a quarter of it) and are sampled as ordinary inputs.
 */
// How it works
// - Centre frequency equals linear multiplier times two-to-E times 38.4 kHz.
// - Programming fields only accept writes while the PLL is off.
// - Zero loop multiplier or reference divider acts as one.
// - Zero linear multiplier disables PLL and forces the oscillator.
// - Switching waits three old then three new source cycles, output held.
// - Selected source is halved, giving a balanced duty cycle.
// - Bypass bit skips halving when the oscillator is selected.
// - Select bit chooses which source drives the base clock.
// - Selecting the VCO source is refused while the PLL is off.
// - Turning the PLL off is refused while VCO source selected.
// - Enable and select cannot change together; use two writes.
// - Select one means divided VCO, zero means oscillator.
`timescale 1ns/100ps
module pbc_top
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic osc_clk_i,
	input wire logic pclk_i,
	input wire logic osc_halving_bypass_bit_i,
	input wire logic ctl_wr_i,
	input wire logic [pbc_pkg::CTL_W-1:0] ctl_wdata_i,
	input wire logic mul_hi_wr_i,
	input wire logic mul_lo_wr_i,
	input wire logic lin_wr_i,
	input wire logic div_wr_i,
	input wire logic [7:0] wdata_i,
	output logic [pbc_pkg::CTL_W-1:0] pll_control_reg_o,
	output logic [pbc_pkg::MUL_W-1:0] loop_mult_o,
	output logic [pbc_pkg::LIN_W-1:0] vco_linear_range_reg_o,
	output logic [pbc_pkg::DIV_W-1:0] reference_divider_reg_o,
	output logic [pbc_pkg::MUL_W-1:0] eff_loop_mult_o,
	output logic [pbc_pkg::DIV_W-1:0] eff_ref_div_o,
	output logic pll_active_o,
	output logic [31:0] vrs_hz_o,
	output logic sel_vco_o,
	output logic switching_o,
	output logic base_clock_output_o
);
	import pbc_pkg::*;

	function automatic logic [31:0] at_least_one(input logic [31:0] v);
		at_least_one = (v == 32'h0) ? 32'h1 : v;
	endfunction : at_least_one

	// ********************************************************
	// Programming registers
	// ********************************************************
	logic on_ff, bcs_ff;
	logic [PRE_W-1:0] pre_ff;
	logic [VPR_W-1:0] vpr_ff;
	logic [MUL_W-1:0] mul_ff;
	logic [LIN_W-1:0] lin_ff;
	logic [DIV_W-1:0] div_ff;

	wire prog_ok = ~on_ff;
	wire lin_zero = lin_ff == 8'h00;
	wire w_on = ctl_wdata_i[CTL_ON_BIT];
	wire w_bcs = ctl_wdata_i[CTL_BCS_BIT];
	// Changing both in one write is refused for both
	wire both_chg = (w_on != on_ff) && (w_bcs != bcs_ff);
	// Clearing enable refused while VCO selected
	wire on_ok = ~both_chg && (w_on || ~bcs_ff);
	// Setting select refused while off or L is zero
	wire bcs_ok = ~both_chg && (~w_bcs || (on_ff && ~lin_zero));
	wire nxt_on = (ctl_wr_i && on_ok) ? w_on : on_ff;
	// Zero L also forces the oscillator back in
	wire nxt_bcs = lin_zero ? 1'b0 :
		((ctl_wr_i && bcs_ok) ? w_bcs : bcs_ff);
	wire [PRE_W-1:0] nxt_pre = (ctl_wr_i && prog_ok) ?
		ctl_wdata_i[CTL_PRE_LSB +: PRE_W] : pre_ff;
	wire [VPR_W-1:0] nxt_vpr = (ctl_wr_i && prog_ok) ?
		ctl_wdata_i[CTL_VPR_LSB +: VPR_W] : vpr_ff;
	wire [MUL_W-1:0] nxt_mul_hi = {wdata_i[MUL_W-9:0], mul_ff[7:0]};
	wire [MUL_W-1:0] nxt_mul_lo = {mul_ff[MUL_W-1:8], wdata_i};
	wire [MUL_W-1:0] nxt_mul = !prog_ok ? mul_ff :
		mul_hi_wr_i ? nxt_mul_hi :
		mul_lo_wr_i ? nxt_mul_lo : mul_ff;
	wire [LIN_W-1:0] nxt_lin = (lin_wr_i && prog_ok) ? wdata_i : lin_ff;
	wire [DIV_W-1:0] nxt_div = (div_wr_i && prog_ok) ?
		wdata_i[DIV_W-1:0] : div_ff;

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			on_ff <= RST_ON;
			bcs_ff <= RST_BCS;
			pre_ff <= RST_PRE;
			vpr_ff <= RST_VPR;
			mul_ff <= RST_MUL;
			lin_ff <= RST_LIN;
			div_ff <= RST_DIV;
		end
		else
		begin
			on_ff <= nxt_on;
			bcs_ff <= nxt_bcs;
			pre_ff <= nxt_pre;
			vpr_ff <= nxt_vpr;
			mul_ff <= nxt_mul;
			lin_ff <= nxt_lin;
			div_ff <= nxt_div;
		end
	end

	assign pll_control_reg_o = {2'h0, on_ff, bcs_ff, pre_ff, vpr_ff};
	assign loop_mult_o = mul_ff;
	assign vco_linear_range_reg_o = lin_ff;
	assign reference_divider_reg_o = div_ff;

	// ********************************************************
	// Synthesis values seen by the analog loop
	// ********************************************************
	logic [MUL_W-1:0] eff_mul_ff;
	logic [DIV_W-1:0] eff_div_ff;
	logic active_ff;
	logic [31:0] vrs_ff;
	wire [31:0] mul_w = at_least_one({20'h0, mul_ff});
	wire [31:0] div_w = at_least_one({28'h0, div_ff});
	wire [31:0] nxt_vrs = (32'(lin_ff) << vpr_ff) * F_NOM_HZ;
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			eff_mul_ff <= '0;
			eff_div_ff <= '0;
			active_ff <= 1'b0;
			vrs_ff <= '0;
		end
		else
		begin
			eff_mul_ff <= mul_w[MUL_W-1:0];
			eff_div_ff <= div_w[DIV_W-1:0];
			active_ff <= on_ff & ~lin_zero;
			vrs_ff <= nxt_vrs;
		end
	end
	assign eff_loop_mult_o = eff_mul_ff;
	assign eff_ref_div_o = eff_div_ff;
	assign pll_active_o = active_ff;
	assign vrs_hz_o = vrs_ff;

	// ********************************************************
	// Glitch-free base clock selector
	// ********************************************************
	logic osc_lvl, osc_rise, pck_lvl, pck_rise;
	pbc_clk_sync u_osc_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(osc_clk_i),
		.level_o(osc_lvl),
		.rise_o(osc_rise)
	);
	pbc_clk_sync u_pck_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(pclk_i),
		.level_o(pck_lvl),
		.rise_o(pck_rise)
	);

	pbc_sel_t st_ff, nxt_st;
	logic cur_ff, nxt_cur;
	logic [1:0] cnt_ff, nxt_cnt;
	logic half_ff, nxt_half;
	logic out_ff, nxt_out;
	wire want = bcs_ff & active_ff;
	wire old_rise = cur_ff ? pck_rise : osc_rise;
	wire new_rise = want ? pck_rise : osc_rise;
	wire src_lvl = cur_ff ? pck_lvl : osc_lvl;
	wire bypass = ~cur_ff & osc_halving_bypass_bit_i;
	wire last = cnt_ff == 2'(SETTLE_CYC - 1);

	always_comb
	begin
		nxt_st = st_ff;
		nxt_cur = cur_ff;
		nxt_cnt = cnt_ff;
		nxt_half = half_ff;
		nxt_out = out_ff;
		unique case (st_ff)
			PBC_RUN:
			begin
				if (want != cur_ff)
				begin
					nxt_st = PBC_STOP_OLD;
					nxt_cnt = 2'h0;
				end
				else if (bypass)
					nxt_out = src_lvl;
				else if (old_rise)
				begin
					nxt_half = ~half_ff;
					nxt_out = ~half_ff;
				end
			end
			PBC_STOP_OLD:
			begin
				// Output held; wait out the old source
				if (old_rise)
				begin
					nxt_cnt = cnt_ff + 2'h1;
					if (last)
					begin
						nxt_st = PBC_START_NEW;
						nxt_cnt = 2'h0;
					end
				end
			end
			PBC_START_NEW:
			begin
				if (new_rise)
				begin
					nxt_cnt = cnt_ff + 2'h1;
					if (last)
					begin
						nxt_st = PBC_RUN;
						nxt_cur = want;
					end
				end
			end
			default:
				nxt_st = PBC_RUN;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_ff <= PBC_RUN;
			cur_ff <= 1'b0;
			cnt_ff <= 2'h0;
			half_ff <= 1'b0;
			out_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			cur_ff <= nxt_cur;
			cnt_ff <= nxt_cnt;
			half_ff <= nxt_half;
			out_ff <= nxt_out;
		end
	end
	assign sel_vco_o = cur_ff;
	assign switching_o = st_ff != PBC_RUN;
	assign base_clock_output_o = out_ff;
endmodule : pbc_top

// >>> pbc_checker.sv
/*
 * Assertion checker for the PLL programming and base clock selector.
 * Bound into pbc_top at the foot of this file; sees its ports only.
 */
`timescale 1ns/100ps
module pbc_checker
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic ctl_wr_i,
	input wire logic [pbc_pkg::CTL_W-1:0] ctl_wdata_i,
	input wire logic lin_wr_i,
	input wire logic [pbc_pkg::CTL_W-1:0] pll_control_reg_o,
	input wire logic [pbc_pkg::LIN_W-1:0] vco_linear_range_reg_o,
	input wire logic [pbc_pkg::MUL_W-1:0] loop_mult_o,
	input wire logic [pbc_pkg::DIV_W-1:0] reference_divider_reg_o,
	input wire logic [pbc_pkg::MUL_W-1:0] eff_loop_mult_o,
	input wire logic [pbc_pkg::DIV_W-1:0] eff_ref_div_o,
	input wire logic pll_active_o,
	input wire logic sel_vco_o,
	input wire logic switching_o,
	input wire logic base_clock_output_o
);
	import pbc_pkg::*;
	// ********************************************************
	// Helpers and properties
	// ********************************************************
	logic up_ff;
	wire on_b = pll_control_reg_o[CTL_ON_BIT];
	wire sel_b = pll_control_reg_o[CTL_BCS_BIT];
	// Derived outputs lag a cycle, so skip the first edge after reset
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
		if (!rst_n_i)
			up_ff <= 1'b0;
		else
			up_ff <= 1'b1;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_sw_start;
		$rose(switching_o);
	endsequence
	sequence s_sw_end;
		##[1:300] !switching_o;
	endsequence
	AST_PROG_LOCK: assert property (
		ctl_wr_i && on_b |=> $stable(pll_control_reg_o[3:0]))
		else $error("prescaler or range changed while on");
	AST_LIN_LOCK: assert property (
		lin_wr_i && on_b |=> $stable(vco_linear_range_reg_o))
		else $error("linear multiplier changed while on");
	AST_ZERO_AS_ONE: assert property (
		up_ff |-> eff_ref_div_o == ($past(reference_divider_reg_o) == 4'h0 ?
		4'h1 : $past(reference_divider_reg_o)) && eff_loop_mult_o ==
		($past(loop_mult_o) == 12'h000 ? 12'h001 : $past(loop_mult_o)))
		else $error("zero multiplier or divider not shown as one");
	AST_L_ZERO: assert property (
		up_ff && vco_linear_range_reg_o == 8'h00 |=> !pll_active_o)
		else $error("pll active with zero linear multiplier");
	AST_SEL_NEEDS_ON: assert property (
		!on_b |-> !sel_b)
		else $error("vco selected while pll off");
	AST_OFF_REFUSED: assert property (
		ctl_wr_i && sel_b |=> on_b)
		else $error("pll turned off while vco selected");
	AST_BOTH_REFUSED: assert property (
		ctl_wr_i && ctl_wdata_i[5] != on_b && ctl_wdata_i[4] != sel_b
		|=> $stable(pll_control_reg_o[5:4]))
		else $error("enable and select changed in one write");
	AST_HOLD: assert property (
		switching_o && $past(switching_o) |-> $stable(base_clock_output_o))
		else $error("output moved during transition");
	AST_SW_BOUND: assert property (
		s_sw_start |-> s_sw_end)
		else $error("transition did not finish");
	AST_SEL_DONE: assert property (
		$fell(switching_o) |-> sel_vco_o == sel_b)
		else $error("source after transition differs from select");
endmodule : pbc_checker

bind pbc_top pbc_checker u_chk (.*);

// >>> tb_pbc_top.sv
/*
 * Self-checking bench for pbc_top: interlocks, zero values and rates.
 * Assumes the checker is bound in from its own file.
 */
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
	$display("unexpected at %0t: %0h vs %0h", $time, a, b); end end
module tb_pbc_top;
	import pbc_pkg::*;
	// ********************************************************
	// Stimulus, tasks and sequence
	// ********************************************************
	typedef struct {logic [7:0] d; logic [7:0] q;} pbc_row_t;
	logic ref_clk_i = 0, rst_n_i = 0, osc_clk_i = 0, pclk_i = 0;
	logic osc_halving_bypass_bit_i = 0, ctl_wr_i = 0, mul_hi_wr_i = 0;
	logic mul_lo_wr_i = 0, lin_wr_i = 0, div_wr_i = 0;
	logic [7:0] ctl_wdata_i = 0, wdata_i = 0, pll_control_reg_o;
	logic [7:0] vco_linear_range_reg_o;
	logic [11:0] loop_mult_o, eff_loop_mult_o;
	logic [3:0] reference_divider_reg_o, eff_ref_div_o;
	logic [31:0] vrs_hz_o;
	logic pll_active_o, sel_vco_o, switching_o, base_clock_output_o;
	int err_total = 0, n_tests = 0;
	pbc_row_t rows [9] = '{'{8'h2E, 8'h20}, '{8'h10, 8'h20},
		'{8'h30, 8'h30}, '{8'h00, 8'h30}, '{8'h20, 8'h20},
		'{8'h00, 8'h00}, '{8'h06, 8'h06}, '{8'h1A, 8'h0A}, '{8'h22, 8'h22}};
	pbc_top DUT (.*);
	initial forever #5 ref_clk_i = ~ref_clk_i;
	// Half period off the 5 ns grid, so edges never meet a ref rise
	initial forever #43.2 osc_clk_i = ~osc_clk_i;
	initial forever #60 pclk_i = ~pclk_i;
	task close_out;
		$display("errors %0d, checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	// Strobe order: control, mult high, mult low, linear, divider
	task put(input logic [4:0] s, input logic [7:0] d);
		@(posedge ref_clk_i);
		{ctl_wr_i, mul_hi_wr_i, mul_lo_wr_i, lin_wr_i, div_wr_i} <= s;
		ctl_wdata_i <= d;
		wdata_i <= d;
		@(posedge ref_clk_i);
		{ctl_wr_i, mul_hi_wr_i, mul_lo_wr_i, lin_wr_i, div_wr_i} <= 5'h00;
		repeat (3) @(posedge ref_clk_i);
		#1;
	endtask : put
	task settle;
		for (int w = 0; w < 300 && switching_o !== 1'b0; w++)
			@(posedge ref_clk_i);
		#1;
		`CHK(switching_o, 1'b0)
	endtask : settle
	// Counts output rises over 480 cycles; sampling jitter allows one
	task rate(input int lo, input int hi);
		int n;
		logic p;
		n = 0;
		p = base_clock_output_o;
		repeat (480)
		begin
			@(posedge ref_clk_i);
			#1;
			if (base_clock_output_o && !p)
				n++;
			p = base_clock_output_o;
		end
		`CHK(n inside {[lo:hi]}, 1'b1)
	endtask : rate
	initial
	begin
		#200000;
		err_total++;
		close_out;
	end
	initial
	begin
		repeat (8) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		foreach (rows[i])
		begin
			put(5'h10, rows[i].d);
			settle;
			`CHK(pll_control_reg_o, rows[i].q)
			`CHK(sel_vco_o, rows[i].q[4])
		end
		put(5'h10, 8'h02);
		put(5'h08, 8'h00);
		put(5'h04, 8'h00);
		put(5'h01, 8'h00);
		put(5'h02, 8'h00);
		put(5'h10, 8'h22);
		`CHK(eff_loop_mult_o, 12'h001)
		`CHK(eff_ref_div_o, 4'h1)
		`CHK(pll_active_o, 1'b0)
		put(5'h10, 8'h32);
		`CHK(pll_control_reg_o, 8'h22)
		put(5'h10, 8'h02);
		put(5'h08, 8'h03);
		put(5'h04, 8'hD1);
		put(5'h02, 8'hD0);
		put(5'h10, 8'h22);
		put(5'h02, 8'h55);
		put(5'h04, 8'h11);
		put(5'h01, 8'h07);
		`CHK(loop_mult_o, 12'h3D1)
		`CHK(eff_loop_mult_o, 12'h3D1)
		`CHK(reference_divider_reg_o, 4'h0)
		`CHK(eff_ref_div_o, 4'h1)
		`CHK(vco_linear_range_reg_o, 8'hD0)
		`CHK(pll_active_o, 1'b1)
		`CHK(vrs_hz_o, 32'((32'hD0 << 2) * F_NOM_HZ))
		rate(26, 30);
		@(posedge ref_clk_i);
		osc_halving_bypass_bit_i <= 1'b1;
		rate(54, 58);
		put(5'h10, 8'h32);
		settle;
		`CHK(sel_vco_o, 1'b1)
		rate(19, 21);
		@(posedge ref_clk_i);
		rst_n_i <= 1'b0;
		#1;
		`CHK(pll_control_reg_o, 8'h20)
		`CHK(loop_mult_o, 12'h040)
		`CHK(reference_divider_reg_o, 4'h1)
		`CHK(eff_loop_mult_o, 12'h000)
		`CHK(pll_active_o, 1'b0)
		`CHK(switching_o, 1'b0)
		`CHK(base_clock_output_o, 1'b0)
		`CHK(sel_vco_o, 1'b0)
		repeat (2) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		@(posedge ref_clk_i);
		#1;
		`CHK(pll_active_o, 1'b1)
		`CHK(eff_loop_mult_o, 12'h040)
		`CHK(vrs_hz_o, 32'(32'h40 * F_NOM_HZ))
		close_out;
	end
endmodule : tb_pbc_top
